//--- hw/gauge_serial_map.svh
`ifndef GAUGE_SERIAL_MAP_SVH
`define GAUGE_SERIAL_MAP_SVH

`define CLK_HZ 20000000
`define BAUD_MIN 75
`define TALK_PERIOD_MS 5000
`define MS_PER_S 1000
`define SYNC_SETTLE 3'h3
`define CHAR_LF 8'h0A

// switch word: bit n-1 is switch n, on = 1
`define SW_MODE 0
`define SW_RTS_STD 1
`define SW_FRAME_LO 2
`define SW_FRAME_HI 4
`define SW_BAUD_LO 5
`define SW_BAUD_HI 7

// framing codes {sw3, sw4, sw5}
`define FRAME_8N2 3'h7
`define FRAME_8E1 3'h6
`define FRAME_8O1 3'h5
`define FRAME_8N1 3'h4
`define FRAME_7E1 3'h3
`define FRAME_7O1 3'h2
`define FRAME_7E2 3'h1
`define FRAME_7O2 3'h0

`endif

//--- hw/gauge_serial_pkg.sv
package gauge_serial_pkg;

    typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_type;

    typedef struct packed {
        logic eight;
        parity_type par;
        logic two_stop;
    } frame_type;

    typedef struct packed {
        logic cmd_mode;
        logic rts_std;
        frame_type frame;
        logic [2:0] baud_code;
        logic hs_force;
        logic dcd_force;
    } cfg_type;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } cmd_type;

    typedef struct packed {
        logic req;
        logic all;
    } talk_type;

    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_type;
    typedef enum {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_type;

endpackage

//--- hw/msg_buffer.sv
`timescale 1ns/10ps
module msg_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule

//--- hw/gauge_serial_port.sv
// Function
// R01: configuration switches are read once after power-up only.
// R02: three switches pick baud, 9600 all on down to 75 all off.
// R03: three framing switches pick data bits, parity and stop bits.
// R04: default is 9600 8N1 with carrier, clear and ready forced true.
// R05: mode switch on gives command-response, off gives talk-only output.
// R06: talk-only requests a three-reading message about every 5 seconds.
// R07: without the secondary gauge module only the ion reading is sent.
// R08: each sent byte waits for clear-to-send and data-set-ready both true.
// R09: the force switch makes clear-to-send and data-set-ready always true.
// R10: characters seen with carrier false are dropped unless forced; none while RTS.
// R11: RTS stays deasserted from power-up until a first message arrives; the pin sits low until capture, the asserted level when inverted.
// R12: RTS asserts at received terminator, drops after reply terminator is sent.
// R13: polarity switch on gives modem RTS polarity, off gives inverted.
// R14: terminal-ready output is asserted whenever powered.
// R15: received characters are buffered until a line-feed terminator.
// R16: start low, data LSB first, optional parity, one or two stops high.
// R17: framing switch codes follow the separate framing code table.
`timescale 1ns/10ps
`include "gauge_serial_map.svh"
module gauge_serial_port import gauge_serial_pkg::*; #(
    parameter int CLK_HZ = `CLK_HZ,
    parameter int TALK_CYCLES = `TALK_PERIOD_MS * (`CLK_HZ / `MS_PER_S),
    parameter int DEPTH = 64,
    parameter int AW = 6,
    parameter int CW = 24,
    parameter int TW = 28
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] cfg_switch,
    input wire logic hs_force_sw,
    input wire logic dcd_force_sw,
    input wire logic rxd,
    input wire logic cts,
    input wire logic dsr,
    input wire logic dcd,
    input wire logic secondary_present,
    input wire logic [7:0] reply_data,
    input wire logic reply_valid,
    output logic reply_ready,
    output logic txd,
    output logic rts,
    output logic dtr,
    output cmd_type cmd,
    output talk_type talk,
    output logic cfg_done
);
    localparam int PW = 15;

    function automatic logic [CW-1:0] bit_cycles(input logic [2:0] code);
        bit_cycles = CW'(CLK_HZ / (`BAUD_MIN << code)); // [R02]
    endfunction

    function automatic frame_type frame_decode(input logic [2:0] code);
        frame_type f;
        f = '{eight: 1'b1, par: PAR_NONE, two_stop: 1'b0};
        case (code) // [R03] [R17]
            `FRAME_8N2: f = '{eight: 1'b1, par: PAR_NONE, two_stop: 1'b1};
            `FRAME_8E1: f = '{eight: 1'b1, par: PAR_EVEN, two_stop: 1'b0};
            `FRAME_8O1: f = '{eight: 1'b1, par: PAR_ODD, two_stop: 1'b0};
            `FRAME_8N1: f = '{eight: 1'b1, par: PAR_NONE, two_stop: 1'b0};
            `FRAME_7E1: f = '{eight: 1'b0, par: PAR_EVEN, two_stop: 1'b0};
            `FRAME_7O1: f = '{eight: 1'b0, par: PAR_ODD, two_stop: 1'b0};
            `FRAME_7E2: f = '{eight: 1'b0, par: PAR_EVEN, two_stop: 1'b1};
            default: f = '{eight: 1'b0, par: PAR_ODD, two_stop: 1'b1};
        endcase
        frame_decode = f;
    endfunction

    // switch n sits at bit n-1, but each code reads its lowest switch as msb
    function automatic logic [2:0] sw_order(input logic [2:0] s);
        sw_order = {s[0], s[1], s[2]};
    endfunction

    // pins pass two flops before any use
    logic [PW-1:0] pin_meta_reg;
    logic [PW-1:0] pin_sync_reg;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= {cfg_switch, hs_force_sw, dcd_force_sw, rxd, cts, dsr, dcd, secondary_present};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    wire [7:0] sw_s = pin_sync_reg[14:7];
    wire hs_force_s = pin_sync_reg[6];
    wire dcd_force_s = pin_sync_reg[5];
    wire rxd_s = pin_sync_reg[4];
    wire cts_s = pin_sync_reg[3];
    wire dsr_s = pin_sync_reg[2];
    wire dcd_s = pin_sync_reg[1];
    wire secondary_s = pin_sync_reg[0];

    // switches latched once; later changes need a power cycle
    cfg_type cfg_reg;
    logic cfg_done_reg;
    logic [2:0] settle_reg;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_reg <= '0;
            cfg_done_reg <= 1'b0;
            settle_reg <= '0;
        end else if (!cfg_done_reg) begin
            settle_reg <= settle_reg + 3'h1;
            if (settle_reg == `SYNC_SETTLE) begin
                cfg_done_reg <= 1'b1; // [R01]
                cfg_reg.cmd_mode <= sw_s[`SW_MODE]; // [R05]
                cfg_reg.rts_std <= sw_s[`SW_RTS_STD];
                cfg_reg.frame <= frame_decode(sw_order(sw_s[`SW_FRAME_HI:`SW_FRAME_LO])); // [R03]
                cfg_reg.baud_code <= sw_order(sw_s[`SW_BAUD_HI:`SW_BAUD_LO]); // [R02] [R04] all on is 9600
                cfg_reg.hs_force <= hs_force_s;
                cfg_reg.dcd_force <= dcd_force_s;
            end
        end
    end

    wire [CW-1:0] full_bit = bit_cycles(cfg_reg.baud_code);
    wire [CW-1:0] half_bit = full_bit >> 1;
    wire [2:0] last_bit = cfg_reg.frame.eight ? 3'h7 : 3'h6;
    wire par_on = cfg_reg.frame.par != PAR_NONE;
    wire par_odd = cfg_reg.frame.par == PAR_ODD;
    wire hs_ok = cfg_reg.hs_force | (cts_s & dsr_s); // [R08] [R09]
    wire dcd_ok = cfg_reg.dcd_force | dcd_s;
    logic rts_active_reg;

    // receiver
    rx_state_type rx_state_reg;
    logic [CW-1:0] rx_cnt_reg;
    logic [2:0] rx_bit_reg;
    logic [7:0] rx_shift_reg;
    logic rx_par_reg;
    logic rx_bad_reg;
    wire rx_tick = rx_cnt_reg == '0;
    wire rx_last_stop = !cfg_reg.frame.two_stop || rx_bit_reg != 3'h0;
    wire [7:0] rx_char = cfg_reg.frame.eight ? rx_shift_reg : {1'b0, rx_shift_reg[7:1]};
    wire rx_store = rx_state_reg == RX_STOP && rx_tick && rx_last_stop && rxd_s && !rx_bad_reg
        && dcd_ok && !rts_active_reg && cfg_reg.cmd_mode; // [R10] [R12]

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg <= '0;
            rx_bit_reg <= '0;
            rx_shift_reg <= '0;
            rx_par_reg <= 1'b0;
            rx_bad_reg <= 1'b0;
        end else begin
            rx_cnt_reg <= rx_cnt_reg - CW'(1);
            if (!dcd_ok) begin
                rx_bad_reg <= 1'b1; // [R10]
            end
            case (rx_state_reg)
                RX_IDLE: begin
                    if (cfg_done_reg && !rxd_s) begin
                        rx_state_reg <= RX_START; // [R15]
                        rx_cnt_reg <= half_bit;
                        rx_bad_reg <= !dcd_ok;
                        rx_par_reg <= 1'b0;
                        rx_bit_reg <= '0;
                    end
                end
                RX_START: begin
                    if (rx_tick) begin
                        rx_state_reg <= rxd_s ? RX_IDLE : RX_DATA; // [R16] glitch rejected
                        rx_cnt_reg <= full_bit - CW'(1);
                    end
                end
                RX_DATA: begin
                    if (rx_tick) begin
                        rx_shift_reg <= {rxd_s, rx_shift_reg[7:1]}; // [R16]
                        rx_par_reg <= rx_par_reg ^ rxd_s;
                        rx_bit_reg <= rx_bit_reg + 3'h1;
                        rx_cnt_reg <= full_bit - CW'(1);
                        if (rx_bit_reg == last_bit) begin
                            rx_state_reg <= par_on ? RX_PAR : RX_STOP;
                            rx_bit_reg <= '0;
                        end
                    end
                end
                RX_PAR: begin
                    if (rx_tick) begin
                        if ((rx_par_reg ^ rxd_s) != par_odd) begin
                            rx_bad_reg <= 1'b1;
                        end
                        rx_state_reg <= RX_STOP;
                        rx_cnt_reg <= full_bit - CW'(1);
                    end
                end
                RX_STOP: begin
                    if (rx_tick) begin
                        // ends mid stop bit so a following start edge is not missed
                        if (rx_last_stop || !rxd_s) begin
                            rx_state_reg <= RX_IDLE;
                        end else begin
                            rx_bit_reg <= 3'h1;
                            rx_cnt_reg <= full_bit - CW'(1);
                        end
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // message store and readout toward the parser
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW-1:0] msg_end_reg;
    logic rd_busy_reg;
    logic rd_pend_reg;
    logic rd_last_pend_reg;
    logic [7:0] buf_q;
    wire rx_is_lf = rx_char == `CHAR_LF;
    // last slot kept for the terminator; overlong text is truncated
    wire buf_room = wr_ptr_reg != AW'(DEPTH - 1);
    wire buf_we = rx_store && (buf_room || rx_is_lf); // [R15]
    wire lf_stored = buf_we && rx_is_lf;
    wire rd_at_end = rd_ptr_reg == msg_end_reg;

    msg_buffer #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .we(buf_we),
        .waddr(wr_ptr_reg),
        .wdata(rx_char),
        .raddr(rd_ptr_reg),
        .rdata(buf_q)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            msg_end_reg <= '0;
            rd_busy_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            rd_last_pend_reg <= 1'b0;
            cmd <= '0;
        end else begin
            rd_pend_reg <= rd_busy_reg;
            rd_last_pend_reg <= rd_busy_reg && rd_at_end;
            cmd <= '{valid: rd_pend_reg, last: rd_last_pend_reg, data: buf_q};
            if (lf_stored) begin
                wr_ptr_reg <= '0;
                msg_end_reg <= wr_ptr_reg;
                rd_ptr_reg <= '0;
                rd_busy_reg <= 1'b1;
            end else if (buf_we) begin
                wr_ptr_reg <= wr_ptr_reg + AW'(1); // [R15]
            end
            if (rd_busy_reg) begin
                rd_ptr_reg <= rd_ptr_reg + AW'(1);
                if (rd_at_end) begin
                    rd_busy_reg <= 1'b0;
                end
            end
        end
    end

    // transmitter
    tx_state_type tx_state_reg;
    logic [CW-1:0] tx_cnt_reg;
    logic [2:0] tx_bit_reg;
    logic [7:0] tx_shift_reg;
    logic tx_par_reg;
    logic tx_lf_reg;
    wire tx_tick = tx_cnt_reg == '0;
    wire tx_accept = reply_valid && reply_ready;
    wire tx_last_stop = !cfg_reg.frame.two_stop || tx_bit_reg != 3'h0;
    wire tx_done = tx_state_reg == TX_STOP && tx_tick && tx_last_stop;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_state_reg <= TX_IDLE;
            tx_cnt_reg <= '0;
            tx_bit_reg <= '0;
            tx_shift_reg <= '0;
            tx_par_reg <= 1'b0;
            tx_lf_reg <= 1'b0;
            txd <= 1'b1;
            reply_ready <= 1'b0;
        end else begin
            tx_cnt_reg <= tx_cnt_reg - CW'(1);
            case (tx_state_reg)
                TX_IDLE: begin
                    reply_ready <= cfg_done_reg && !tx_accept;
                    if (tx_accept) begin
                        tx_state_reg <= TX_WAIT;
                        tx_shift_reg <= reply_data;
                        tx_lf_reg <= reply_data == `CHAR_LF;
                        tx_par_reg <= 1'b0;
                    end
                end
                TX_WAIT: begin
                    if (hs_ok) begin
                        tx_state_reg <= TX_START; // [R08]
                        txd <= 1'b0; // [R16]
                        tx_cnt_reg <= full_bit - CW'(1);
                        tx_bit_reg <= '0;
                    end
                end
                TX_START, TX_DATA: begin
                    if (tx_tick) begin
                        tx_cnt_reg <= full_bit - CW'(1);
                        if (tx_state_reg == TX_DATA && tx_bit_reg == last_bit) begin
                            tx_state_reg <= par_on ? TX_PAR : TX_STOP;
                            txd <= par_on ? (tx_par_reg ^ par_odd) : 1'b1;
                            tx_bit_reg <= '0;
                        end else begin
                            if (tx_state_reg == TX_DATA) begin
                                tx_bit_reg <= tx_bit_reg + 3'h1;
                            end
                            tx_state_reg <= TX_DATA;
                            txd <= tx_shift_reg[0]; // [R16] lsb first
                            tx_par_reg <= tx_par_reg ^ tx_shift_reg[0];
                            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        end
                    end
                end
                TX_PAR: begin
                    if (tx_tick) begin
                        tx_state_reg <= TX_STOP;
                        txd <= 1'b1;
                        tx_cnt_reg <= full_bit - CW'(1);
                    end
                end
                TX_STOP: begin
                    if (tx_tick) begin
                        tx_cnt_reg <= full_bit - CW'(1);
                        if (tx_last_stop) begin
                            tx_state_reg <= TX_IDLE;
                            reply_ready <= 1'b1;
                        end else begin
                            tx_bit_reg <= 3'h1;
                        end
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // hold-off and fixed lines; set beats clear
    logic [TW-1:0] talk_cnt_reg;
    wire talk_fire = cfg_done_reg && !cfg_reg.cmd_mode && talk_cnt_reg == '0;
    // held at zero until capture so the first message follows power-up
    wire [TW-1:0] talk_cnt_next = talk_fire ? TW'(TALK_CYCLES - 1) : (cfg_done_reg ? talk_cnt_reg - TW'(1) : '0);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rts_active_reg <= 1'b0; // [R11]
            rts <= 1'b0;
            dtr <= 1'b1;
            talk_cnt_reg <= '0;
            talk <= '0;
            cfg_done <= 1'b0;
        end else begin
            if (lf_stored) begin
                rts_active_reg <= 1'b1; // [R12]
            end else if (tx_done && tx_lf_reg) begin
                rts_active_reg <= 1'b0; // [R12]
            end
            rts <= cfg_done_reg && (cfg_reg.rts_std ? rts_active_reg : !rts_active_reg); // [R11] [R13]
            dtr <= 1'b1; // [R14]
            cfg_done <= cfg_done_reg;
            talk_cnt_reg <= talk_cnt_next; // [R06]
            talk <= '{req: talk_fire, all: secondary_s}; // [R06] [R07]
        end
    end

    sequence s_lf_in;
        lf_stored;
    endsequence
    sequence s_readout;
        rd_busy_reg ##1 rd_pend_reg ##1 cmd.valid;
    endsequence

    a_cfg_frozen: assert property (@(posedge clk) disable iff (sys_rst) // [R01]
        cfg_done_reg |=> $stable(cfg_reg) && cfg_done_reg) else $error("config changed after capture");
    a_hs_wait: assert property (@(posedge clk) disable iff (sys_rst) // [R08]
        tx_state_reg == TX_WAIT && !hs_ok |=> tx_state_reg == TX_WAIT && txd) else $error("sent without handshake");
    a_start_low: assert property (@(posedge clk) disable iff (sys_rst) // [R16]
        tx_state_reg == TX_WAIT && hs_ok |=> !txd [*2]) else $error("start bit not low");
    a_rts_rise: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
        $rose(rts_active_reg) |-> $past(lf_stored)) else $error("rts raised without terminator");
    a_rts_pin: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
        cfg_done_reg |=> rts == (cfg_reg.rts_std ~^ $past(rts_active_reg))) else $error("rts polarity wrong");
    a_dtr_on: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
        ##1 dtr) else $error("dtr dropped");
    a_no_rx_holdoff: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
        rts_active_reg || (!dcd_ok && rx_state_reg != RX_IDLE) |-> !buf_we) else $error("char taken while blocked");
    a_talk_mode: assert property (@(posedge clk) disable iff (sys_rst) // [R05]
        talk.req |-> !cfg_reg.cmd_mode ##1 !talk.req) else $error("talk request in command mode");
    a_lf_readout: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
        s_lf_in |=> s_readout) else $error("message not handed on");
    a_boot_quiet: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
        !cfg_done_reg |-> !rts_active_reg && !rts) else $error("rts asserted at power-up");
endmodule

//--- testbench/host_port.sv
`timescale 1ns/10ps
module host_port #(
    parameter int BIT = 8
) (
    input wire logic clk,
    output logic rxd,
    input wire logic txd
);
    // idle line rests at mark level
    initial rxd = 1'b1;

    // start low, data lsb first, one high stop; rts is not watched, so bytes go out even during the hold-off
    task automatic send_byte(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk);
            rxd = f[i];
            repeat (BIT - 1) @(negedge clk);
        end
    endtask

    // mid-bit sampling on the falling edge keeps clear of the launch edge
    task automatic get_byte(output logic [7:0] d, output logic ok);
        int n;
        n = 0;
        d = 8'h00;
        while (txd !== 1'b0 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        repeat (BIT / 2) @(negedge clk);
        ok = (n < 4000) && (txd === 1'b0);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(negedge clk);
            d[i] = txd;
        end
        repeat (BIT) @(negedge clk);
        ok = ok && (txd === 1'b1);
    endtask

    // ten raw line samples from the start bit on, for any framing
    task automatic get_bits(output logic [9:0] f, input int len);
        int n;
        n = 0;
        f = '0;
        while (txd !== 1'b0 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        repeat (len / 2) @(negedge clk);
        for (int i = 0; i < 10; i++) begin
            f[i] = txd;
            repeat (len) @(negedge clk);
        end
    endtask
endmodule

//--- testbench/gauge_controller_serial_port_tb.sv
`timescale 1ns/10ps
module gauge_controller_serial_port_tb import gauge_serial_pkg::*;;
    localparam int TALK = 2000;
    logic clk = 1'b0;
    logic sys_rst, hs_force_sw, dcd_force_sw, rxd, cts, dsr, dcd, secondary_present;
    logic [7:0] cfg_switch, reply_data;
    logic reply_valid, reply_ready, txd, rts, dtr, cfg_done;
    cmd_type cmd;
    talk_type talk;
    int error_cnt = 0;
    int total_checks = 0;
    int cmd_cnt = 0;

    always #25 clk = ~clk;
    always @(negedge clk) if (cmd.valid === 1'b1) cmd_cnt++;

    // 76800 Hz keeps a 9600 bit at 8 cycles
    gauge_serial_port #(.CLK_HZ(76800), .TALK_CYCLES(TALK)) dut (.clk(clk), .sys_rst(sys_rst),
        .cfg_switch(cfg_switch), .hs_force_sw(hs_force_sw), .dcd_force_sw(dcd_force_sw), .rxd(rxd),
        .cts(cts), .dsr(dsr), .dcd(dcd), .secondary_present(secondary_present), .reply_data(reply_data),
        .reply_valid(reply_valid), .reply_ready(reply_ready), .txd(txd), .rts(rts), .dtr(dtr),
        .cmd(cmd), .talk(talk), .cfg_done(cfg_done));

    host_port #(.BIT(8)) host (.clk(clk), .rxd(rxd), .txd(txd));

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic do_reset(input logic [7:0] sw);
        int n;
        @(negedge clk);
        sys_rst = 1'b1;
        cfg_switch = sw;
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        n = 0;
        while (cfg_done !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        chk(16'(cfg_done), 16'h0001);
    endtask

    task automatic offer(input logic [7:0] d);
        int n;
        n = 0;
        while (reply_ready !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        reply_valid = 1'b1;
        reply_data = d;
        @(posedge clk);
        @(negedge clk);
        reply_valid = 1'b0;
    endtask

    task automatic wait_req(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (talk.req !== 1'b1 && n < 3000);
    endtask

    task automatic t_power;
        chk(16'(dtr), 16'h0001);
        chk(16'(rts), 16'h0000);
        chk(16'(txd), 16'h0001);
    endtask

    task automatic rx_msg(input logic [7:0] a, input logic [7:0] lf, input logic [7:0] exp);
        int n;
        fork
            begin
                host.send_byte(a);
                host.send_byte(lf);
            end
            begin
                n = 0;
                while (cmd.valid !== 1'b1 && n < 400) begin
                    @(negedge clk);
                    n++;
                end
                chk({6'h00, cmd.valid, cmd.last, cmd.data}, {8'h02, exp});
                @(negedge clk);
                chk({6'h00, cmd.valid, cmd.last, cmd.data}, 16'h030A);
            end
        join
    endtask

    task automatic t_rx;
        host.send_byte(8'h5A); // carrier false, must vanish
        dcd = 1'b1;
        rx_msg(8'h41, 8'h0A, 8'h41);
        repeat (4) @(negedge clk);
        chk(16'(rts), 16'h0001);
    endtask

    task automatic t_tx;
        logic [7:0] d;
        logic ok;
        int seen;
        seen = cmd_cnt;
        host.send_byte(8'h0A); // sent during the hold-off, must vanish
        repeat (10) @(negedge clk);
        chk(16'(cmd_cnt - seen), 16'h0000);
        offer(8'h4F);
        repeat (40) @(negedge clk);
        chk(16'(txd), 16'h0001); // held by clear-to-send false
        dsr = 1'b0;
        cts = 1'b1;
        repeat (20) @(negedge clk);
        chk(16'(txd), 16'h0001); // held by data-set-ready false
        dsr = 1'b1;
        host.get_byte(d, ok);
        chk({7'h00, ok, d}, 16'h014F);
        chk(16'(rts), 16'h0001);
        fork
            offer(8'h0A);
            host.get_byte(d, ok);
        join
        chk({7'h00, ok, d}, 16'h010A);
        repeat (6) @(negedge clk);
        chk(16'(rts), 16'h0000);
    endtask

    task automatic t_frame;
        logic [9:0] f;
        do_reset(8'hEB); // seven data bits, odd parity, one stop
        rx_msg(8'hC1, 8'h8A, 8'h41); // top bit carries the parity
        fork
            offer(8'h41);
            host.get_bits(f, 8);
        join
        chk(16'(f), 16'h0382);
        fork
            offer(8'h0A);
            host.get_bits(f, 8);
        join
        chk(16'(f), 16'h0314);
        chk(16'(rts), 16'h0000);
    endtask

    task automatic t_talk;
        int n;
        int seen;
        logic [7:0] d;
        logic ok;
        dcd_force_sw = 1'b1;
        hs_force_sw = 1'b1;
        do_reset(8'hE4); // talk-only, inverted rts
        chk(16'(rts), 16'h0001); // deasserted reads high when inverted
        wait_req(n);
        wait_req(n);
        chk(16'(n), 16'(TALK));
        chk(16'(talk.all), 16'h0001);
        secondary_present = 1'b0;
        cfg_switch = 8'hE7; // too late, capture already done
        repeat (5) @(negedge clk);
        chk(16'(talk.all), 16'h0000);
        cts = 1'b0;
        dsr = 1'b0;
        fork
            offer(8'h2C);
            host.get_byte(d, ok);
        join
        chk({7'h00, ok, d}, 16'h012C); // handshake ignored when forced
        seen = cmd_cnt;
        host.send_byte(8'h0A);
        repeat (40) @(negedge clk);
        chk(16'(cmd_cnt - seen), 16'h0000); // nothing stored in talk-only
        chk(16'(rts), 16'h0001);
        wait_req(n);
        wait_req(n);
        chk(16'(n), 16'(TALK)); // still talk-only
    endtask

    initial begin
        sys_rst = 1'b1;
        cfg_switch = 8'hE7;
        hs_force_sw = 1'b0;
        dcd_force_sw = 1'b0;
        cts = 1'b0;
        dsr = 1'b1;
        dcd = 1'b0;
        secondary_present = 1'b1;
        reply_data = 8'h00;
        reply_valid = 1'b0;
        do_reset(8'hE7);
        t_power;
        t_rx;
        t_tx;
        t_frame;
        t_talk;
        complete_run;
    end

    // whole run needs about 9000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        complete_run;
    end
endmodule
